// ==== timer_chan_defines.svh ====
// register indices, field positions, reset values and bus codes for the channel block
`ifndef TIMER_CHAN_DEFINES_SVH
`define TIMER_CHAN_DEFINES_SVH
// register indices; the byte address is four times the index
`define CHAN_CTRL_IDX 6'h05
`define CHAN_VALH_IDX 6'h06
`define CHAN_VALL_IDX 6'h07
`define CHAN_STRIDE 6'h03
`define START_HIGH_IDX 6'h17
`define START_LOW_IDX 6'h18
`define STATUS_IDX 6'h19
// channel control field positions
`define CTRL_FLAG_BIT 7
`define CTRL_IRQ_EN_BIT 6
`define CTRL_MODE_B_BIT 5
`define CTRL_MODE_A_BIT 4
`define CTRL_ELS_B_BIT 3
`define CTRL_ELS_A_BIT 2
// reset values
`define CTRL_RESET 8'h00
`define START_RESET 16'h0000
`define STATUS_RESET 8'h00
`define COUNTER_ZERO 16'h0000
// bus response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== timer_chan_pkg.sv ====
// types shared by the channel value and status block
`default_nettype none
package timer_chan_pkg;
  localparam int NUM_CHAN = 6;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [5:0] waddr;
    logic [7:0] wdata;
    logic wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [5:0][7:0] ctrl;
    logic [5:0][15:0] value;
    logic [5:0] armed;
    logic [5:0] rd_latched;
    logic [5:0] rd_first_low;
    logic [5:0][15:0] rd_buf;
    logic [5:0][15:0] wr_buf;
    logic [5:0] wr_got_h;
    logic [5:0] wr_got_l;
    logic [15:0] start;
    logic [15:0] st_buf;
    logic st_got_h;
    logic st_got_l;
    logic [1:0] clk_sel_prev;
    logic clock_started;
    logic counter_inited;
    logic counter_zero_start;
  } chan_state_t;
endpackage
`default_nettype wire

// ==== timer_channel_value_status.sv ====
// channel value, counter start value and flag mirror registers behind an AXI4-Lite slave
//
// Contract
// RL1: edge/level select B bit writable only while write protection is off.
// RL2: two lowest channel control bits read zero and ignore writes.
// RL3: input modes: reading one value byte latches both until other byte read.
// RL4: any channel control write releases that channel's read latch.
// RL5: value writes are ignored while the channel is in an input mode.
// RL6: debug halt freezes read latches, even when value bytes are read.
// RL7: value reads during debug halt return live register, not buffer.
// RL8: output modes: value byte writes buffer, moved in by update mechanism.
// RL9: control write with enhanced features off resets value write coherency.
// RL10: debug halt freezes write latches; value writes go straight in.
// RL11: halt writes keep partial sequences; completed buffers load afterwards.
// RL12: channel i value high at 6h+3i, low at 7h+3i, i 0..5.
// RL13: counter start byte writes go to a buffer, then update the register.
// RL14: debug halt: counter start writes load directly, latches untouched.
// RL15: first clock select from zero starts counter at zero unless initialised.
// RL16: software loads start value, writes counter, then selects a clock.
// RL17: each status bit mirrors its channel's event flag.
// RL18: status read then 0x00 write clears every flag read as set.
// RL19: flag clears only by writing 0 after a read showing it set.
// RL20: event between read and clearing write makes that write ineffective.
// RL21: hardware sets each channel flag when its channel event occurs.
// RL22: software uses status only with enhanced on, pairing 1, center 0.
// RL23: write protect off reads 1 when protected bits are writable.
// RL24: each channel keeps its own read latch and write buffer state.
`timescale 1ns/1ps
`default_nettype none
`include "timer_chan_defines.svh"

module timer_channel_value_status
  import timer_chan_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [7:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic [2:0] ARPROT,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic DEBUG_HALT,
  input wire logic WRITE_PROTECT_OFF,
  input wire logic ENHANCED_FEATURES_ON,
  input wire logic [5:0] CHANNEL_INPUT_MODE,
  input wire logic [5:0] CHANNEL_EVENT,
  input wire logic [15:0] COUNTER_VALUE,
  input wire logic BUFFER_UPDATE,
  input wire logic COUNTER_WRITE,
  input wire logic [1:0] CLOCK_SOURCE_SEL,
  output logic [95:0] CHANNEL_VALUE,
  output logic [47:0] CHANNEL_CONTROL,
  output logic [5:0] CHANNEL_EVENT_FLAG,
  output logic [15:0] COUNTER_START_VALUE,
  output logic COUNTER_ZERO_START
);

  chan_state_t s;
  chan_state_t next_s;
  logic [5:0] ridx;
  logic [5:0] base;

  assign ridx = ARADDR[7:2];

  // next state: buffer update, bus write, bus read, then hardware events last
  always_comb
  begin
    next_s = s;
    base = 6'h00;
    next_s.counter_zero_start = 1'b0;

    // buffered value moves in only when both bytes arrived and no halt
    for (int i = 0; i < NUM_CHAN; i++)
    begin
      if (BUFFER_UPDATE && s.wr_got_h[i] && s.wr_got_l[i] && !DEBUG_HALT)
      begin
        next_s.value[i] = s.wr_buf[i]; // RL8 RL11
        next_s.wr_got_h[i] = 1'b0;
        next_s.wr_got_l[i] = 1'b0;
      end
    end

    // counter start updates from its buffer once both halves are written
    if (s.st_got_h && s.st_got_l && !DEBUG_HALT)
    begin
      next_s.start = s.st_buf; // RL13
      next_s.st_got_h = 1'b0;
      next_s.st_got_l = 1'b0;
    end

    // address and data channels are taken independently, in either order
    if (AWVALID && s.awready)
    begin
      next_s.aw_got = 1'b1;
      next_s.waddr = AWADDR[7:2];
    end
    if (WVALID && s.wready)
    begin
      next_s.w_got = 1'b1;
      next_s.wdata = WDATA[7:0];
      next_s.wstrb = WSTRB[0];
    end
    if (s.bvalid && BREADY)
      next_s.bvalid = 1'b0;

    // register write, once both halves of the request are held
    if (s.aw_got && s.w_got && !s.bvalid)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `RESP_SLVERR;
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        base = 6'(`CHAN_STRIDE * i);
        if (s.waddr == `CHAN_CTRL_IDX + base)
        begin
          next_s.bresp = `RESP_OKAY;
          if (s.wstrb)
          begin
            // a flag only falls if it was seen set and no event came since
            if (!s.wdata[`CTRL_FLAG_BIT] && s.armed[i])
              next_s.ctrl[i][`CTRL_FLAG_BIT] = 1'b0; // RL19
            next_s.armed[i] = 1'b0;
            next_s.ctrl[i][`CTRL_IRQ_EN_BIT] = s.wdata[`CTRL_IRQ_EN_BIT];
            // protected bits follow the module-wide write protection
            if (WRITE_PROTECT_OFF) // RL23
            begin
              next_s.ctrl[i][`CTRL_MODE_B_BIT] = s.wdata[`CTRL_MODE_B_BIT];
              next_s.ctrl[i][`CTRL_MODE_A_BIT] = s.wdata[`CTRL_MODE_A_BIT];
              next_s.ctrl[i][`CTRL_ELS_B_BIT] = s.wdata[`CTRL_ELS_B_BIT];
              next_s.ctrl[i][`CTRL_ELS_A_BIT] = s.wdata[`CTRL_ELS_A_BIT]; // RL1
            end
            next_s.ctrl[i][1:0] = 2'h0; // RL2
            next_s.rd_latched[i] = 1'b0; // RL4
            if (!ENHANCED_FEATURES_ON)
            begin
              next_s.wr_got_h[i] = 1'b0; // RL9
              next_s.wr_got_l[i] = 1'b0;
            end
          end
        end
        if (s.waddr == `CHAN_VALH_IDX + base)
        begin
          next_s.bresp = `RESP_OKAY;
          // input modes drop the write silently
          if (s.wstrb && !CHANNEL_INPUT_MODE[i]) // RL5
          begin
            if (DEBUG_HALT)
              next_s.value[i][15:8] = s.wdata; // RL10
            else
            begin
              next_s.wr_buf[i][15:8] = s.wdata; // RL8 RL24
              next_s.wr_got_h[i] = 1'b1;
            end
          end
        end
        if (s.waddr == `CHAN_VALL_IDX + base) // RL12
        begin
          next_s.bresp = `RESP_OKAY;
          if (s.wstrb && !CHANNEL_INPUT_MODE[i]) // RL5
          begin
            if (DEBUG_HALT)
              next_s.value[i][7:0] = s.wdata; // RL10 RL11
            else
            begin
              next_s.wr_buf[i][7:0] = s.wdata; // RL8 RL24
              next_s.wr_got_l[i] = 1'b1;
            end
          end
        end
      end
      if (s.waddr == `START_HIGH_IDX)
      begin
        next_s.bresp = `RESP_OKAY;
        if (s.wstrb && DEBUG_HALT)
          next_s.start[15:8] = s.wdata; // RL14
        else if (s.wstrb)
        begin
          next_s.st_buf[15:8] = s.wdata; // RL13
          next_s.st_got_h = 1'b1;
        end
      end
      if (s.waddr == `START_LOW_IDX)
      begin
        next_s.bresp = `RESP_OKAY;
        if (s.wstrb && DEBUG_HALT)
          next_s.start[7:0] = s.wdata; // RL14
        else if (s.wstrb)
        begin
          next_s.st_buf[7:0] = s.wdata; // RL13
          next_s.st_got_l = 1'b1;
        end
      end
      if (s.waddr == `STATUS_IDX)
      begin
        next_s.bresp = `RESP_OKAY;
        if (s.wstrb)
        begin
          for (int i = 0; i < NUM_CHAN; i++)
          begin
            if (!s.wdata[i] && s.armed[i])
              next_s.ctrl[i][`CTRL_FLAG_BIT] = 1'b0; // RL18 RL19
            next_s.armed[i] = 1'b0;
          end
        end
      end
    end

    // read: answered with data on the same edge that takes the address
    if (s.rvalid && RREADY)
      next_s.rvalid = 1'b0;
    if (ARVALID && s.arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = `RESP_SLVERR;
      next_s.rdata = 8'h00;
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        base = 6'(`CHAN_STRIDE * i);
        if (ridx == `CHAN_CTRL_IDX + base)
        begin
          next_s.rresp = `RESP_OKAY;
          next_s.rdata = {s.ctrl[i][7:2], 2'h0}; // RL2
          if (s.ctrl[i][`CTRL_FLAG_BIT])
            next_s.armed[i] = 1'b1;
        end
        if (ridx == `CHAN_VALH_IDX + base)
        begin
          next_s.rresp = `RESP_OKAY;
          // halt bypasses the latch and leaves it as it was
          if (DEBUG_HALT || !CHANNEL_INPUT_MODE[i])
            next_s.rdata = s.value[i][15:8]; // RL6 RL7
          else if (s.rd_latched[i])
          begin
            next_s.rdata = s.rd_buf[i][15:8];
            if (s.rd_first_low[i])
              next_s.rd_latched[i] = 1'b0; // RL3
          end
          else
          begin
            next_s.rdata = s.value[i][15:8];
            next_s.rd_buf[i] = s.value[i]; // RL3 RL24
            next_s.rd_latched[i] = 1'b1;
            next_s.rd_first_low[i] = 1'b0;
          end
        end
        if (ridx == `CHAN_VALL_IDX + base)
        begin
          next_s.rresp = `RESP_OKAY;
          if (DEBUG_HALT || !CHANNEL_INPUT_MODE[i])
            next_s.rdata = s.value[i][7:0]; // RL6 RL7
          else if (s.rd_latched[i])
          begin
            next_s.rdata = s.rd_buf[i][7:0];
            if (!s.rd_first_low[i])
              next_s.rd_latched[i] = 1'b0; // RL3
          end
          else
          begin
            next_s.rdata = s.value[i][7:0];
            next_s.rd_buf[i] = s.value[i]; // RL3 RL24
            next_s.rd_latched[i] = 1'b1;
            next_s.rd_first_low[i] = 1'b1;
          end
        end
      end
      if (ridx == `START_HIGH_IDX)
      begin
        next_s.rresp = `RESP_OKAY;
        next_s.rdata = s.start[15:8];
      end
      if (ridx == `START_LOW_IDX)
      begin
        next_s.rresp = `RESP_OKAY;
        next_s.rdata = s.start[7:0];
      end
      if (ridx == `STATUS_IDX)
      begin
        next_s.rresp = `RESP_OKAY;
        for (int i = 0; i < NUM_CHAN; i++)
        begin
          next_s.rdata[i] = s.ctrl[i][`CTRL_FLAG_BIT]; // RL17
          if (s.ctrl[i][`CTRL_FLAG_BIT])
            next_s.armed[i] = 1'b1; // RL18
        end
      end
    end

    // events come last so a set beats a clear in the same cycle
    for (int i = 0; i < NUM_CHAN; i++)
    begin
      if (CHANNEL_EVENT[i])
      begin
        next_s.ctrl[i][`CTRL_FLAG_BIT] = 1'b1; // RL21
        next_s.armed[i] = 1'b0; // RL20
        if (CHANNEL_INPUT_MODE[i])
          next_s.value[i] = COUNTER_VALUE;
      end
    end

    // first clock selection; the counter itself lives outside
    if (COUNTER_WRITE)
      next_s.counter_inited = 1'b1;
    if (s.clk_sel_prev == 2'h0 && CLOCK_SOURCE_SEL != 2'h0 && !s.clock_started)
    begin
      next_s.clock_started = 1'b1;
      next_s.counter_zero_start = !s.counter_inited && !COUNTER_WRITE; // RL15
    end
    next_s.clk_sel_prev = CLOCK_SOURCE_SEL;

    // readies reopen only when the previous answer is gone
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
  end

  // the whole state in one register
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      s <= '0;
    else
      s <= next_s;
  end

  // outputs straight from the state register
  assign AWREADY = s.awready;
  assign WREADY = s.wready;
  assign BVALID = s.bvalid;
  assign BRESP = s.bresp;
  assign ARREADY = s.arready;
  assign RVALID = s.rvalid;
  assign RRESP = s.rresp;
  assign RDATA = {24'h000000, s.rdata};
  assign CHANNEL_VALUE = s.value;
  assign CHANNEL_CONTROL = s.ctrl;
  assign COUNTER_START_VALUE = s.start;
  assign COUNTER_ZERO_START = s.counter_zero_start;

  // flag mirror for the surrounding timer
  always_comb
  begin
    for (int i = 0; i < NUM_CHAN; i++)
      CHANNEL_EVENT_FLAG[i] = s.ctrl[i][`CTRL_FLAG_BIT];
  end

endmodule // timer_channel_value_status
`default_nettype wire

// ==== timer_channel_value_status_chk.sv ====
// assertion checker for the channel value and flag mirror block
`timescale 1ns/1ps
`default_nettype none
`include "timer_chan_defines.svh"
module timer_channel_value_status_chk (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic ARVALID,
  input wire logic [7:0] ARADDR,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [31:0] RDATA,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [5:0] CHANNEL_INPUT_MODE,
  input wire logic [5:0] CHANNEL_EVENT,
  input wire logic [1:0] CLOCK_SOURCE_SEL,
  input wire logic [95:0] CHANNEL_VALUE,
  input wire logic [47:0] CHANNEL_CONTROL,
  input wire logic [5:0] CHANNEL_EVENT_FLAG,
  input wire logic COUNTER_ZERO_START
);
  logic [5:0] ctl_flag;
  // flag bit of every control byte, gathered for the mirror check
  assign ctl_flag = {CHANNEL_CONTROL[47], CHANNEL_CONTROL[39], CHANNEL_CONTROL[31],
                     CHANNEL_CONTROL[23], CHANNEL_CONTROL[15], CHANNEL_CONTROL[7]};
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  AST_FLAG_SET: assert property ((CHANNEL_EVENT != 6'h00) |=>
    ((CHANNEL_EVENT_FLAG & $past(CHANNEL_EVENT)) == $past(CHANNEL_EVENT))) else $error("flag not set");
  AST_FLAG_MIRROR: assert property (ctl_flag == CHANNEL_EVENT_FLAG)
    else $error("status mirror differs");
  // a status read must return the flags as they stood when the address was taken
  AST_STATUS_COPY: assert property (ARVALID && ARREADY && ARADDR[7:2] == `STATUS_IDX |=>
    RDATA[7:0] == {2'h0, $past(CHANNEL_EVENT_FLAG)}) else $error("status copy differs");
  AST_RSV_ZERO: assert property ((CHANNEL_CONTROL & 48'h030303030303) == 48'h0)
    else $error("reserved control bits set");
  AST_FLAG_CLEAR: assert property (($past(CHANNEL_EVENT_FLAG) & ~CHANNEL_EVENT_FLAG) != 6'h00 |->
    $rose(BVALID)) else $error("flag fell without a write");
  AST_INPUT_NO_WRITE: assert property ($past(CHANNEL_INPUT_MODE[3]) &&
    $changed(CHANNEL_VALUE[63:48]) |-> $past(CHANNEL_EVENT[3])) else $error("input value changed");
  AST_ZERO_START: assert property (COUNTER_ZERO_START |->
    (CLOCK_SOURCE_SEL != 2'h0) ##1 !COUNTER_ZERO_START) else $error("bad zero start pulse");
  AST_READ_ANSWER: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read not answered");
  AST_READ_STANDS: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  AST_WRITE_STANDS: assert property (BVALID && !BREADY |=> BVALID)
    else $error("write response dropped");
  // main scenarios reached
  cover property ($fell(CHANNEL_EVENT_FLAG[0]));
  cover property (COUNTER_ZERO_START);
  cover property (CHANNEL_INPUT_MODE[3] && CHANNEL_EVENT[3]);
endmodule // timer_channel_value_status_chk
`default_nettype wire

// ==== timer_channel_value_status_tb_top.sv ====
// self-checking bench for the channel value and flag mirror block
`timescale 1ns/1ps
`default_nettype none
`include "timer_chan_defines.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module timer_channel_value_status_tb_top import timer_chan_pkg::*;;
  logic CLK, RESET_N, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY;
  logic RVALID, RREADY, DEBUG_HALT, WRITE_PROTECT_OFF, ENHANCED_FEATURES_ON;
  logic BUFFER_UPDATE, COUNTER_WRITE, COUNTER_ZERO_START;
  logic [7:0] AWADDR, ARADDR, rdat;
  logic [2:0] AWPROT, ARPROT;
  logic [31:0] WDATA, RDATA;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP, CLOCK_SOURCE_SEL, resp, rd_resp;
  logic [5:0] CHANNEL_INPUT_MODE, CHANNEL_EVENT, CHANNEL_EVENT_FLAG;
  logic [15:0] COUNTER_VALUE, COUNTER_START_VALUE;
  logic [95:0] CHANNEL_VALUE;
  logic [47:0] CHANNEL_CONTROL;
  int fail_count, comparisons, hits;
  timer_channel_value_status dut (.CLK, .RESET_N, .AWADDR, .AWPROT, .AWVALID, .AWREADY, .WDATA,
    .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARPROT, .ARVALID, .ARREADY,
    .RDATA, .RRESP, .RVALID, .RREADY, .DEBUG_HALT, .WRITE_PROTECT_OFF, .ENHANCED_FEATURES_ON,
    .CHANNEL_INPUT_MODE, .CHANNEL_EVENT, .COUNTER_VALUE, .BUFFER_UPDATE, .COUNTER_WRITE,
    .CLOCK_SOURCE_SEL, .CHANNEL_VALUE, .CHANNEL_CONTROL, .CHANNEL_EVENT_FLAG,
    .COUNTER_START_VALUE, .COUNTER_ZERO_START);
  function automatic logic [15:0] cv(int i);
    return CHANNEL_VALUE[16 * i +: 16];
  endfunction
  // one bus write; address and data released each as soon as taken
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic aw, w;
    int n;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    AWADDR <= {idx, 2'b00};
    WDATA <= {24'h0, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    while ((aw || w) && n < 50)
    begin
      @(posedge CLK);
      n++;
      if (AWREADY) aw = 1'b0;
      if (WREADY) w = 1'b0;
      AWVALID <= aw;
      WVALID <= w;
    end
    while (!BVALID && n < 50)
    begin
      @(posedge CLK);
      n++;
    end
    // ready only once the answer stands, so the response must hold a cycle
    BREADY <= 1'b1;
    @(posedge CLK);
    resp = BRESP;
    BREADY <= 1'b0;
    if (n >= 50) fail_count++;
    @(posedge CLK);
  endtask
  // one bus read, then compare the byte
  task automatic rchk(input logic [5:0] idx, input logic [7:0] e);
    int n;
    n = 0;
    ARADDR <= {idx, 2'b00};
    ARVALID <= 1'b1;
    do
    begin
      @(posedge CLK);
      n++;
    end while (!ARREADY && n < 50);
    ARVALID <= 1'b0;
    while (!RVALID && n < 50)
    begin
      @(posedge CLK);
      n++;
    end
    // ready only once the data stands, so the data must hold a cycle
    RREADY <= 1'b1;
    @(posedge CLK);
    rdat = RDATA[7:0];
    rd_resp = RRESP;
    RREADY <= 1'b0;
    if (n >= 50) fail_count++;
    @(posedge CLK);
    `CHK("rdata", e, rdat)
  endtask
  // one-cycle event and update strobes
  task automatic pulse(input logic [5:0] e, input logic u);
    CHANNEL_EVENT <= e;
    BUFFER_UPDATE <= u;
    @(posedge CLK);
    CHANNEL_EVENT <= 6'h00;
    BUFFER_UPDATE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic finish_test;
    if (fail_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // clock
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // watchdog, far beyond the few hundred cycles the tests take
  initial
  begin
    #200000;
    fail_count++;
    finish_test;
  end
  // main sequence
  initial
  begin
    {RESET_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, DEBUG_HALT, WRITE_PROTECT_OFF} = 8'h00;
    {BUFFER_UPDATE, COUNTER_WRITE, CHANNEL_INPUT_MODE, CHANNEL_EVENT} = 14'h0;
    {AWADDR, ARADDR, WDATA, AWPROT, ARPROT, CLOCK_SOURCE_SEL, COUNTER_VALUE} = 72'h0;
    ENHANCED_FEATURES_ON = 1'b1;
    WSTRB = 4'h1;
    repeat (12) @(posedge CLK);
    RESET_N <= 1'b1;
    @(posedge CLK);
    wr(6'h3f, 8'h00);
    `CHK("unmapped resp", `RESP_SLVERR, resp)
    rchk(`STATUS_IDX, 8'h00);
    `CHK("read resp", `RESP_OKAY, rd_resp)
    rchk(6'h3e, 8'h00);
    `CHK("unmapped rresp", `RESP_SLVERR, rd_resp)
    for (int i = 0; i < NUM_CHAN; i++)
    begin
      wr(`CHAN_VALH_IDX + 6'(3 * i), 8'h10 + 8'(i));
      wr(`CHAN_VALL_IDX + 6'(3 * i), 8'h20 + 8'(i));
      `CHK("buffered", 16'h0, cv(i))
    end
    pulse(6'h00, 1'b1);
    for (int i = 0; i < NUM_CHAN; i++)
    begin
      `CHK("loaded", {8'h10 + 8'(i), 8'h20 + 8'(i)}, cv(i))
      rchk(`CHAN_VALL_IDX + 6'(3 * i), 8'h20 + 8'(i));
    end
    wr(`START_HIGH_IDX, 8'hab);
    wr(`START_LOW_IDX, 8'hcd);
    `CHK("write resp", `RESP_OKAY, resp)
    repeat (2) @(posedge CLK);
    `CHK("start", 16'habcd, COUNTER_START_VALUE)
    DEBUG_HALT <= 1'b1;
    wr(`START_HIGH_IDX, 8'h12);
    `CHK("halt start", 16'h12cd, COUNTER_START_VALUE)
    DEBUG_HALT <= 1'b0;
    wr(`CHAN_VALH_IDX, 8'h55);
    DEBUG_HALT <= 1'b1;
    wr(`CHAN_VALL_IDX, 8'h66);
    pulse(6'h00, 1'b1);
    `CHK("halt value", 16'h1066, cv(0))
    DEBUG_HALT <= 1'b0;
    wr(`CHAN_VALL_IDX, 8'h77);
    pulse(6'h00, 1'b1);
    `CHK("resumed", 16'h5577, cv(0))
    // a control write drops the half-written high byte
    ENHANCED_FEATURES_ON <= 1'b0;
    wr(6'h09, 8'h99);
    wr(6'h08, 8'h00);
    wr(6'h0a, 8'haa);
    pulse(6'h00, 1'b1);
    `CHK("reset coherency", 16'h1121, cv(1))
    ENHANCED_FEATURES_ON <= 1'b1;
    wr(6'h0b, 8'h7f);
    `CHK("protected ctrl", 8'h40, CHANNEL_CONTROL[23:16])
    WRITE_PROTECT_OFF <= 1'b1;
    wr(6'h0b, 8'h7f);
    rchk(6'h0b, 8'h7c);
    // channel 3 in input capture
    CHANNEL_INPUT_MODE <= 6'h08;
    COUNTER_VALUE <= 16'h1234;
    pulse(6'h08, 1'b0);
    wr(6'h0f, 8'hff);
    `CHK("input value", 16'h1234, cv(3))
    rchk(6'h0f, 8'h12);
    COUNTER_VALUE <= 16'h5678;
    pulse(6'h08, 1'b0);
    rchk(6'h10, 8'h34);
    rchk(6'h0f, 8'h56);
    COUNTER_VALUE <= 16'h9abc;
    pulse(6'h08, 1'b0);
    DEBUG_HALT <= 1'b1;
    rchk(6'h10, 8'hbc);
    DEBUG_HALT <= 1'b0;
    rchk(6'h10, 8'h78);
    rchk(6'h0f, 8'h9a);
    wr(6'h0e, 8'h00);
    COUNTER_VALUE <= 16'hdef0;
    pulse(6'h08, 1'b0);
    rchk(6'h10, 8'hf0);
    pulse(6'h21, 1'b0);
    rchk(`STATUS_IDX, 8'h29);
    pulse(6'h20, 1'b0);
    wr(`STATUS_IDX, 8'h00);
    `CHK("flags", 6'h20, CHANNEL_EVENT_FLAG)
    rchk(`STATUS_IDX, 8'h20);
    wr(`STATUS_IDX, 8'hff);
    `CHK("flags", 6'h20, CHANNEL_EVENT_FLAG)
    rchk(`STATUS_IDX, 8'h20);
    wr(`STATUS_IDX, 8'h00);
    `CHK("flags", 6'h00, CHANNEL_EVENT_FLAG)
    CLOCK_SOURCE_SEL <= 2'h1;
    hits = 0;
    repeat (8)
    begin
      @(posedge CLK);
      if (COUNTER_ZERO_START === 1'b1) hits++;
    end
    `CHK("zero start", 1, hits)
    // second reset: start value and counter set up before a clock is chosen
    CLOCK_SOURCE_SEL <= 2'h0;
    RESET_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RESET_N <= 1'b1;
    @(posedge CLK);
    wr(`START_HIGH_IDX, 8'h0f);
    wr(`START_LOW_IDX, 8'hed);
    COUNTER_WRITE <= 1'b1;
    @(posedge CLK);
    COUNTER_WRITE <= 1'b0;
    `CHK("start after reset", 16'h0fed, COUNTER_START_VALUE)
    CLOCK_SOURCE_SEL <= 2'h2;
    hits = 0;
    repeat (8)
    begin
      @(posedge CLK);
      if (COUNTER_ZERO_START !== 1'b0) hits++;
    end
    `CHK("initialised start", 0, hits)
    finish_test;
  end
endmodule // timer_channel_value_status_tb_top
bind timer_channel_value_status timer_channel_value_status_chk chk (.CLK, .RESET_N, .ARVALID,
  .ARADDR, .ARREADY, .RVALID, .RREADY, .RDATA, .BVALID, .BREADY, .CHANNEL_INPUT_MODE,
  .CHANNEL_EVENT,
  .CLOCK_SOURCE_SEL, .CHANNEL_VALUE, .CHANNEL_CONTROL, .CHANNEL_EVENT_FLAG, .COUNTER_ZERO_START);
`default_nettype wire
